// file: jtag_sel_cfg.svh
`ifndef JTAG_SEL_CFG_SVH
`define JTAG_SEL_CFG_SVH

// Register offsets on the plain register port (byte addresses).
`define JSEL_CFG_OFS 8'h00
`define JSEL_STAT_OFS 8'h04
`define JSEL_ACT_OFS 8'h08
`define JSEL_CNT_OFS 8'h0C

// Chain configuration register layout and reset value.
`define JSEL_CFG_SP_LSB 0
`define JSEL_CFG_RC_LSB 3
`define JSEL_CFG_RST 6'h00

// Status register layout.
`define JSEL_STAT_EFF_LSB 0
`define JSEL_STAT_SRC_LSB 6
`define JSEL_STAT_SW_LSB 8

// Edge counter register layout.
`define JSEL_CNT_SP_LSB 0
`define JSEL_CNT_RC_LSB 16

// Device counts and widths.
`define JSEL_NDEV 6
`define JSEL_GRP_DEVS 3
`define JSEL_COMMON_W 4

// Position of the test clock inside the common bus.
`define JSEL_TCK_BIT 0

`endif

// file: jtag_sel_pkg.sv
package jtag_sel_pkg;

   // Membership mask of one device group, one bit per device.
   typedef logic [2:0] grp_mask_t;

   // Shared test clock, mode and reset lines of one group.
   typedef logic [3:0] common_t;

   // Where a group takes its membership from.
   typedef enum logic [1:0] {
      SRC_REG = 2'b01,
      SRC_SWITCH = 2'b10
   } src_t;

endpackage : jtag_sel_pkg

// file: chain_if.sv
`timescale 1ns/1ns

// Signals between the selector core and one group's chain router.
interface chain_if;
   jtag_sel_pkg::grp_mask_t sel;
   logic probe_tdi;
   logic [2:0] dev_tdo;
   logic [2:0] dev_tdi;
   logic probe_tdo;

   modport route (
      input sel,
      input probe_tdi,
      input dev_tdo,
      output dev_tdi,
      output probe_tdo
   );

   modport ctl (
      output sel,
      output probe_tdi,
      output dev_tdo,
      input dev_tdi,
      input probe_tdo
   );
endinterface : chain_if

// file: sync2.sv
`timescale 1ns/1ns

module sync2 #(
   parameter int W = 1
) (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   logic [W-1:0] meta_r;

   // Two flip-flops; the first is read only by the second.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= '0;
         o_q <= '0;
      end else begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end

endmodule : sync2

// file: chain_route.sv
`timescale 1ns/1ns

module chain_route (
   chain_if.route ch
);

   logic carry;

   // Walk the devices in fixed order; each selected device splices into the path.
   always_comb begin
      carry = ch.probe_tdi;
      for (int i = 0; i < 3; i++) begin
         ch.dev_tdi[i] = carry;
         if (ch.sel[i]) begin
            carry = ch.dev_tdo[i];
         end
      end
      ch.probe_tdo = carry;
   end

endmodule : chain_route

// file: jtag_chain_selector.sv
// Functional notes
// - Six scan targets are managed and any subset of them, none to all, may be chained.
// - Each group connector offers test-data in, test-data out and a four-line common bus.
// - Each target gets a driven test-data line, a test-data return and a 4-bit common bus.
// - Each group has a 3-bit switch input with one bit per device of the group.
// - A signal-processor switch bit that is ON puts its device into that chain.
// - An unselected device leaves the chain and all of its JTAG drives go high-impedance.
// - With all signal-processor switch bits OFF, membership comes from the config register.
// - The reconfigurable group switch bits include a device when ON and exclude it when OFF.
// - With all reconfigurable switch bits OFF, membership comes from a host read/write register.
// - After reset the reconfigurable half of the config register selects no device.
// - After reset the signal-processor half of the config register selects no device.
// - Both groups' chain settings live together in one 6-bit register feeding the selector.
`timescale 1ns/1ns
`include "jtag_sel_cfg.svh"

module jtag_chain_selector (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_sp_probe_tdi,
   output logic o_sp_probe_tdo,
   input wire logic [3:0] i_sp_probe_common_bus,
   input wire logic i_rc_probe_tdi,
   output logic o_rc_probe_tdo,
   input wire logic [3:0] i_reconfig_probe_common_bus,
   output logic [5:0] o_dev_tdi,
   output logic [5:0] o_dev_tdi_oe,
   input wire logic [5:0] i_dev_tdo,
   output logic [23:0] o_dev_common,
   output logic [5:0] o_dev_common_oe,
   input wire logic [2:0] i_sp_switch_bits,
   input wire logic [2:0] i_reconfig_switch_bits,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata
);

   localparam int SYNC_W = 22;

   // Synchronised pin inputs.
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_s;
   logic sp_tdi_s;
   logic rc_tdi_s;
   jtag_sel_pkg::common_t sp_common_s;
   jtag_sel_pkg::common_t rc_common_s;
   logic [5:0] dev_tdo_s;
   jtag_sel_pkg::grp_mask_t sp_sw_s;
   jtag_sel_pkg::grp_mask_t rc_sw_s;

   // Configuration, selection and status state.
   logic [5:0] cfg_r;
   jtag_sel_pkg::grp_mask_t sp_sel;
   jtag_sel_pkg::grp_mask_t rc_sel;
   jtag_sel_pkg::src_t sp_src;
   jtag_sel_pkg::src_t rc_src;
   logic sp_tck_d_r;
   logic rc_tck_d_r;
   logic sp_tck_rise;
   logic rc_tck_rise;
   logic [1:0] act_r;
   logic [1:0] act_nxt;
   logic [15:0] sp_cnt_r;
   logic [15:0] rc_cnt_r;
   logic [31:0] rdata_nxt;
   logic hit_cfg;
   logic hit_stat;
   logic hit_act;
   logic hit_cnt;

   chain_if sp_ch ();
   chain_if rc_ch ();

   // Membership of a group: switches when any is ON, else the register half.
   function automatic jtag_sel_pkg::grp_mask_t pick_sel(
      input jtag_sel_pkg::grp_mask_t sw,
      input jtag_sel_pkg::grp_mask_t reg_bits
   );
      pick_sel = (|sw) ? sw : reg_bits;
   endfunction : pick_sel

   // Source indication of a group for the status register.
   function automatic jtag_sel_pkg::src_t pick_src(
      input jtag_sel_pkg::grp_mask_t sw
   );
      pick_src = (|sw) ? jtag_sel_pkg::SRC_SWITCH : jtag_sel_pkg::SRC_REG;
   endfunction : pick_src

   // Gather every pin that comes from outside the clock domain.
   assign pins_raw = {i_sp_probe_tdi, i_rc_probe_tdi, i_sp_probe_common_bus,
                      i_reconfig_probe_common_bus, i_dev_tdo, i_sp_switch_bits,
                      i_reconfig_switch_bits};

   // switch inputs pass the synchroniser with the rest of the pins.
   sync2 #(
      .W(SYNC_W)
   ) u_sync (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_d(pins_raw),
      .o_q(pins_s)
   );

   // Split the synchronised vector back into its fields.
   assign sp_tdi_s = pins_s[21];
   assign rc_tdi_s = pins_s[20];
   assign sp_common_s = pins_s[19:16];
   assign rc_common_s = pins_s[15:12];
   assign dev_tdo_s = pins_s[11:6];
   assign sp_sw_s = pins_s[5:3];
   assign rc_sw_s = pins_s[2:0];

   // switch bits ON select signal processors.
   // all switches OFF hands control to the register.
   assign sp_sel = pick_sel(sp_sw_s, cfg_r[`JSEL_CFG_SP_LSB +: `JSEL_GRP_DEVS]);
   assign sp_src = pick_src(sp_sw_s);

   // reconfigurable switch bits include or exclude devices.
   // all switches OFF hands control to the host register.
   assign rc_sel = pick_sel(rc_sw_s, cfg_r[`JSEL_CFG_RC_LSB +: `JSEL_GRP_DEVS]);
   assign rc_src = pick_src(rc_sw_s);

   // Feed both chain routers.
   assign sp_ch.sel = sp_sel;
   assign sp_ch.probe_tdi = sp_tdi_s;
   assign sp_ch.dev_tdo = dev_tdo_s[2:0];
   assign rc_ch.sel = rc_sel;
   assign rc_ch.probe_tdi = rc_tdi_s;
   assign rc_ch.dev_tdo = dev_tdo_s[5:3];

   chain_route u_sp_route (
      .ch(sp_ch)
   );

   chain_route u_rc_route (
      .ch(rc_ch)
   );

   // Register decode on the plain port.
   assign hit_cfg = (i_addr == `JSEL_CFG_OFS);
   assign hit_stat = (i_addr == `JSEL_STAT_OFS);
   assign hit_act = (i_addr == `JSEL_ACT_OFS);
   assign hit_cnt = (i_addr == `JSEL_CNT_OFS);

   // Chain configuration register, written by the host.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cfg_r <= `JSEL_CFG_RST;
      end else if (i_wr && hit_cfg) begin
         // one 6-bit store for both groups.
         cfg_r <= i_wdata[5:0];
      end
   end

   // Delayed test clocks for edge detection on the synchronised copies.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sp_tck_d_r <= 1'b0;
         rc_tck_d_r <= 1'b0;
      end else begin
         sp_tck_d_r <= sp_common_s[`JSEL_TCK_BIT];
         rc_tck_d_r <= rc_common_s[`JSEL_TCK_BIT];
      end
   end

   assign sp_tck_rise = sp_common_s[`JSEL_TCK_BIT] & ~sp_tck_d_r;
   assign rc_tck_rise = rc_common_s[`JSEL_TCK_BIT] & ~rc_tck_d_r;

   // Sticky activity flags: a read clears them, a new edge in that cycle wins.
   always_comb begin
      act_nxt = act_r;
      if (i_rd && hit_act) begin
         act_nxt = 2'h0;
      end
      if (sp_tck_rise) begin
         act_nxt[0] = 1'b1;
      end
      if (rc_tck_rise) begin
         act_nxt[1] = 1'b1;
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         act_r <= 2'h0;
      end else begin
         act_r <= act_nxt;
      end
   end

   // Test clock edge counters; any write to their offset restarts them.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sp_cnt_r <= 16'h0000;
         rc_cnt_r <= 16'h0000;
      end else if (i_wr && hit_cnt) begin
         sp_cnt_r <= {15'h0000, sp_tck_rise};
         rc_cnt_r <= {15'h0000, rc_tck_rise};
      end else begin
         sp_cnt_r <= sp_cnt_r + {15'h0000, sp_tck_rise};
         rc_cnt_r <= rc_cnt_r + {15'h0000, rc_tck_rise};
      end
   end

   // Read multiplexer; unmapped offsets read as zero.
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (hit_cfg) begin
         rdata_nxt[5:0] = cfg_r;
      end else if (hit_stat) begin
         rdata_nxt[`JSEL_STAT_EFF_LSB +: 6] = {rc_sel, sp_sel};
         rdata_nxt[`JSEL_STAT_SRC_LSB] = (sp_src == jtag_sel_pkg::SRC_SWITCH);
         rdata_nxt[`JSEL_STAT_SRC_LSB + 1] = (rc_src == jtag_sel_pkg::SRC_SWITCH);
         rdata_nxt[`JSEL_STAT_SW_LSB +: 6] = {rc_sw_s, sp_sw_s};
      end else if (hit_act) begin
         rdata_nxt[1:0] = act_r;
      end else if (hit_cnt) begin
         rdata_nxt[`JSEL_CNT_SP_LSB +: 16] = sp_cnt_r;
         rdata_nxt[`JSEL_CNT_RC_LSB +: 16] = rc_cnt_r;
      end
   end

   // Read data stand only in the cycle after the read strobe.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_rd) begin
         o_rdata <= rdata_nxt;
      end else begin
         o_rdata <= 32'h0000_0000;
      end
   end

   // Connector test-data outputs, one register stage after the routers.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_sp_probe_tdo <= 1'b0;
         o_rc_probe_tdo <= 1'b0;
      end else begin
         o_sp_probe_tdo <= sp_ch.probe_tdo;
         o_rc_probe_tdo <= rc_ch.probe_tdo;
      end
   end

   // Device-facing drives; every path shares the same delay so TCK, TMS and TDI stay aligned.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_dev_tdi <= 6'h00;
         o_dev_common <= 24'h00_0000;
      end else begin
         // test data and common bus to each target.
         o_dev_tdi <= {rc_ch.dev_tdi, sp_ch.dev_tdi};
         o_dev_common <= {rc_common_s, rc_common_s, rc_common_s,
                          sp_common_s, sp_common_s, sp_common_s};
      end
   end

   // Output enables follow membership; excluded devices float.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_dev_tdi_oe <= 6'h00;
         o_dev_common_oe <= 6'h00;
      end else begin
         // any subset of the six targets.
         o_dev_tdi_oe <= {rc_sel, sp_sel};
         o_dev_common_oe <= {rc_sel, sp_sel};
      end
   end

endmodule : jtag_chain_selector

// file: jtag_chain_selector_properties.sv
`timescale 1ns/1ns
module jtag_chain_selector_properties (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_sp_probe_tdi,
   input wire logic o_sp_probe_tdo,
   input wire logic [3:0] i_sp_probe_common_bus,
   input wire logic [5:0] o_dev_tdi,
   input wire logic [5:0] o_dev_tdi_oe,
   input wire logic [5:0] i_dev_tdo,
   input wire logic [23:0] o_dev_common,
   input wire logic [5:0] o_dev_common_oe,
   input wire logic [2:0] i_sp_switch_bits,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   logic [5:0] cfg_wd_r;
   // Holds the last value written to the chain configuration register.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         cfg_wd_r <= 6'h00;
      end else if (i_wr && i_addr == 8'h00) begin
         cfg_wd_r <= i_wdata[5:0];
      end
   end
   sequence s_cfg_wr;
      i_wr && i_addr == 8'h00;
   endsequence
   sequence s_cfg_rd;
      i_rd && i_addr == 8'h00;
   endsequence
   a_rst_chain_empty: assert property ($fell(i_rst) |-> (o_dev_tdi_oe == 6'h00) [*2])
      else $error("device selected right after reset");
   a_oe_pair_match: assert property (o_dev_tdi_oe == o_dev_common_oe)
      else $error("data and common enables differ");
   a_sp_switch_sel: assert property (
      $stable(i_sp_switch_bits) [*4] ##0 i_sp_switch_bits != 3'h0
      |-> o_dev_tdi_oe[2:0] == i_sp_switch_bits)
      else $error("switch selection not applied");
   a_sp_empty_bypass: assert property ((o_dev_tdi_oe[2:0] == 3'h0) [*4]
      |-> o_sp_probe_tdo == $past(i_sp_probe_tdi, 3))
      else $error("empty chain does not bypass");
   a_chain_head_tdi: assert property (o_dev_tdi_oe[0] [*4]
      |-> o_dev_tdi[0] == $past(i_sp_probe_tdi, 3))
      else $error("first device not fed by probe");
   a_chain_tail_tdo: assert property ((o_dev_tdi_oe[2:0] == 3'h1) [*4]
      |-> o_sp_probe_tdo == $past(i_dev_tdo[0], 3))
      else $error("last return not on probe");
   a_common_follow: assert property (o_dev_common_oe[0] [*4]
      |-> o_dev_common[3:0] == $past(i_sp_probe_common_bus, 3))
      else $error("common bus not forwarded");
   a_cfg_read_back: assert property (s_cfg_wr ##1 s_cfg_rd |=> o_rdata == {26'h0, cfg_wd_r})
      else $error("configuration read back wrong");
   a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside read slot");
   a_unmapped_zero: assert property (i_rd && i_addr > 8'h0C |=> o_rdata == 32'h0)
      else $error("unmapped read not zero");
endmodule : jtag_chain_selector_properties

bind jtag_chain_selector jtag_chain_selector_properties u_props (.*);

// file: jtag_target_model.sv
`timescale 1ns/1ns
module jtag_target_model (
   input wire logic i_mclk,
   input wire logic [5:0] i_tdi,
   input wire logic [5:0] i_tdi_oe,
   output logic [5:0] o_tdo
);
   logic babble_r = 1'h0;
   // Changes every cycle so a parked return never looks settled.
   always_ff @(posedge i_mclk) begin
      babble_r <= ~babble_r;
   end
   // A selected target returns its data inverted, a parked one babbles.
   always_comb begin
      for (int k = 0; k < 6; k++) begin
         o_tdo[k] = i_tdi_oe[k] ? ~i_tdi[k] : babble_r;
      end
   end
endmodule : jtag_target_model

// file: tb_jtag_chain_selector.sv
`timescale 1ns/1ns
`define CHK(got, exp) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      n_fail++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
   end \
end
module tb_jtag_chain_selector;
   typedef struct {logic [63:0] e; logic [63:0] k;} note_t;
   note_t exp_q[$];
   logic i_mclk = 1'h0;
   logic i_rst = 1'h1;
   logic tck = 1'h0;
   logic tck_on = 1'h0;
   logic look_r = 1'h0;
   logic rd_p1 = 1'h0;
   logic i_sp_probe_tdi, i_rc_probe_tdi, i_wr, i_rd, o_sp_probe_tdo, o_rc_probe_tdo;
   logic [2:0] csp, crc, i_sp_switch_bits, i_reconfig_switch_bits;
   logic [5:0] o_dev_tdi, o_dev_tdi_oe, i_dev_tdo, o_dev_common_oe;
   logic [7:0] i_addr;
   logic [23:0] o_dev_common;
   logic [31:0] i_wdata, o_rdata;
   logic [63:0] obs;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   jtag_chain_selector u_jtag_chain_selector (.i_mclk(i_mclk), .i_rst(i_rst),
      .i_sp_probe_tdi(i_sp_probe_tdi), .o_sp_probe_tdo(o_sp_probe_tdo),
      .i_sp_probe_common_bus({csp, tck}), .i_rc_probe_tdi(i_rc_probe_tdi),
      .o_rc_probe_tdo(o_rc_probe_tdo), .i_reconfig_probe_common_bus({crc, tck}),
      .o_dev_tdi(o_dev_tdi), .o_dev_tdi_oe(o_dev_tdi_oe), .i_dev_tdo(i_dev_tdo),
      .o_dev_common(o_dev_common), .o_dev_common_oe(o_dev_common_oe),
      .i_sp_switch_bits(i_sp_switch_bits), .i_reconfig_switch_bits(i_reconfig_switch_bits),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));
   jtag_target_model u_jtag_target_model (.i_mclk(i_mclk), .i_tdi(o_dev_tdi),
      .i_tdi_oe(o_dev_tdi_oe), .o_tdo(i_dev_tdo));
   // Read data after a read, otherwise the link outputs.
   assign obs = rd_p1 ? {32'h0, o_rdata} : {20'h0, o_dev_common, o_dev_tdi, o_dev_tdi_oe,
      o_dev_common_oe, o_sp_probe_tdo, o_rc_probe_tdo};
   // Free clock and a probe test clock that runs only within frames.
   always #4 i_mclk = ~i_mclk;
   initial begin
      #3;
      forever #80 tck = tck_on & ~tck;
   end
   // Compares each result with the oldest note as it appears.
   always @(posedge i_mclk) begin
      note_t x;
      if (rd_p1 || look_r) begin
         x = exp_q.pop_front();
         `CHK(obs & x.k, x.e)
      end
      rd_p1 <= i_rd;
   end
   // Cuts a hang short.
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         conclude();
      end
   end
   task automatic conclude();
      if (n_fail == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : conclude
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'h1;
      @(posedge i_mclk);
      i_wr <= 1'h0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] d);
      note_t x;
      x.e = {32'h0, d};
      x.k = {32'h0, 32'hFFFFFFFF};
      exp_q.push_back(x);
      i_addr <= a;
      i_rd <= 1'h1;
      @(posedge i_mclk);
      i_rd <= 1'h0;
      @(posedge i_mclk);
   endtask : rd
   // Predicts settled link outputs: each member passes on the inverted data.
   task automatic check_link(input logic [5:0] m);
      note_t x;
      logic p;
      x.e = {50'h0, m, m, 2'h0};
      x.k = 64'h3FFF;
      p = i_sp_probe_tdi;
      for (int j = 0; j < 6; j++) begin
         if (j == 3) begin
            x.e[1] = p;
            p = i_rc_probe_tdi;
         end
         if (m[j]) begin
            x.e[14 + j] = p;
            x.k[14 + j] = 1'h1;
            x.e[20 + 4 * j +: 4] = (j < 3) ? {csp, 1'h0} : {crc, 1'h0};
            x.k[20 + 4 * j +: 4] = 4'hF;
            p = ~p;
         end
      end
      x.e[0] = p;
      exp_q.push_back(x);
      look_r <= 1'h1;
      @(posedge i_mclk);
      look_r <= 1'h0;
   endtask : check_link
   // Reset, refusals, then every register mask and random switch settings.
   initial begin
      logic [5:0] c, s, m;
      {i_wr, i_rd, i_sp_probe_tdi, i_rc_probe_tdi, csp, crc} = 10'h000;
      {i_sp_switch_bits, i_reconfig_switch_bits, i_addr, i_wdata} = 46'h0;
      void'($urandom(54858));
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'h0;
      @(posedge i_mclk);
      rd(8'h00, 32'h0);
      check_link(6'h00);
      wr(8'h40, 32'hFFFFFFFF);
      rd(8'h10, 32'h0);
      rd(8'h00, 32'h0);
      for (int n = 0; n < 96; n++) begin
         c = (n < 64) ? n[5:0] : 6'($urandom);
         s = (n < 64) ? 6'h00 : 6'($urandom);
         i_sp_switch_bits <= s[2:0];
         i_reconfig_switch_bits <= s[5:3];
         {i_sp_probe_tdi, i_rc_probe_tdi, csp, crc} <= 8'($urandom);
         m[2:0] = (s[2:0] != 3'h0) ? s[2:0] : c[2:0];
         m[5:3] = (s[5:3] != 3'h0) ? s[5:3] : c[5:3];
         wr(8'h00, {26'($urandom), c});
         rd(8'h00, {26'h0, c});
         tck_on <= 1'h1;
         repeat (40) @(posedge i_mclk);
         tck_on <= 1'h0;
         repeat (25) @(posedge i_mclk);
         check_link(m);
         rd(8'h04, {18'h0, s, |s[5:3], |s[2:0], m});
         // Each frame gives two test clock rises per group; a read clears the activity flags.
         rd(8'h08, 32'h3);
         rd(8'h08, 32'h0);
         rd(8'h0C, {16'(2 * (n + 1)), 16'(2 * (n + 1))});
      end
      // A write to the counter offset restarts both counters while the test clock is idle.
      wr(8'h0C, 32'h0);
      rd(8'h0C, 32'h0);
      conclude();
   end
endmodule : tb_jtag_chain_selector
